// File: include/bvs_pkg.sv
package bvs_pkg;

	// bus address of this register bank, arbitrary default
	localparam logic [6:0] DEV_ADDR = 7'h2A;

	localparam logic [7:0] KEY_OFS = 8'h0B;
	localparam logic [7:0] B2_OFS = 8'h0F;
	localparam logic [7:0] B3_OFS = 8'h10;
	localparam logic [7:0] CTL_OFS = 8'h11;

	localparam logic [7:0] KEY_RST = 8'h00;
	localparam logic [7:0] B2_RST = 8'h08;
	localparam logic [7:0] B3_RST = 8'h08;
	localparam logic [7:0] CTL_RST = 8'h06;
	localparam logic [7:0] UNLOCK_KEY = 8'h7D;

	// writable bits; the rest hold their reset value
	localparam logic [7:0] B2_WMASK = 8'hBE;
	localparam logic [7:0] B3_WMASK = 8'h9E;

	localparam int XADJ_BIT = 7;
	localparam int RSVD_BIT = 6;
	localparam int GO_BIT = 7;
	localparam int BYP_BIT = 6;

	localparam logic [5:0] CODE_SEG2 = 6'h18;
	localparam logic [5:0] CODE_SEG3 = 6'h20;
	localparam logic [5:0] CODE_SEG4 = 6'h30;
	localparam logic [5:0] CODE_SEG4_END = 6'h34;
	localparam logic [5:0] CODE_3V0 = 6'h35;
	localparam logic [5:0] CODE_3V1 = 6'h36;
	localparam logic [5:0] CODE_3V2 = 6'h37;

	// millivolt figures
	localparam logic [11:0] MV_0900 = 12'h384;
	localparam logic [11:0] MV_1500 = 12'h5DC;
	localparam logic [11:0] MV_1900 = 12'h76C;
	localparam logic [11:0] MV_2700 = 12'hA8C;
	localparam logic [11:0] MV_3000 = 12'hBB8;
	localparam logic [11:0] MV_3100 = 12'hC1C;
	localparam logic [11:0] MV_3200 = 12'hC80;
	localparam logic [11:0] MV_3300 = 12'hCE4;
	localparam logic [11:0] STEP_FINE = 12'h019;
	localparam logic [11:0] STEP_COARSE = 12'h032;
	localparam logic [11:0] MV_RST = 12'h44C;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_AACK = 9'h004,
		ST_REG = 9'h008,
		ST_RACK = 9'h010,
		ST_WDAT = 9'h020,
		ST_WACK = 9'h040,
		ST_RDAT = 9'h080,
		ST_MACK = 9'h100
	} bvs_state_t;

endpackage

// File: hdl/bvs_i2c_slave.sv
`timescale 1ns/1ns
module bvs_i2c_slave import bvs_pkg::*; (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [7:0] rd_data_i,
	output logic sda_oe_n_o,
	output logic wr_stb_o,
	output logic [7:0] wr_data_o,
	output logic [7:0] ptr_o,
	output logic txn_end_o
);

	bvs_state_t st_r;
	logic scl_q_r, sda_q_r, rw_r;
	logic [2:0] cnt_r;
	logic [7:0] sh_r, tx_r;
	logic scl_rise, scl_fall, start, stop, last;
	logic [7:0] byte_in;

	assign scl_rise = scl_i & ~scl_q_r;
	assign scl_fall = ~scl_i & scl_q_r;
	assign start = scl_i & scl_q_r & sda_q_r & ~sda_i;
	assign stop = scl_i & scl_q_r & ~sda_q_r & sda_i;
	assign last = cnt_r == 3'h7;
	assign byte_in = {sh_r[6:0], sda_i};

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl_i;
			sda_q_r <= sda_i;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r <= ST_IDLE;
			cnt_r <= 3'h0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_o <= 8'h00;
			rw_r <= 1'b0;
		end else if (start) begin
			st_r <= ST_ADDR;
			cnt_r <= 3'h0;
		end else if (stop) begin
			st_r <= ST_IDLE;
		end else if (scl_rise) begin
			unique case (st_r)
				ST_IDLE: begin
				end
				ST_ADDR, ST_REG, ST_WDAT: begin
					sh_r <= byte_in;
					cnt_r <= cnt_r + 3'h1;
					if (last && st_r == ST_ADDR) begin
						rw_r <= sda_i;
						st_r <= (sh_r[6:0] == DEV_ADDR) ? ST_AACK : ST_IDLE;
					end else if (last && st_r == ST_REG) begin
						ptr_o <= byte_in;
						st_r <= ST_RACK;
					end else if (last) begin
						st_r <= ST_WACK;
					end
				end
				ST_AACK: begin
					cnt_r <= 3'h0;
					tx_r <= rd_data_i;
					st_r <= rw_r ? ST_RDAT : ST_REG;
				end
				ST_RACK: st_r <= ST_WDAT;
				ST_WACK: begin
					ptr_o <= ptr_o + 8'h01;
					st_r <= ST_WDAT;
				end
				ST_RDAT: begin
					tx_r <= {tx_r[6:0], 1'b0};
					cnt_r <= cnt_r + 3'h1;
					if (last) begin
						// next byte is fetched before the master acks
						ptr_o <= ptr_o + 8'h01;
						st_r <= ST_MACK;
					end
				end
				ST_MACK: begin
					tx_r <= rd_data_i;
					st_r <= sda_i ? ST_IDLE : ST_RDAT;
				end
			endcase
		end
	end

	// pin changes only while the clock is low
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			sda_oe_n_o <= 1'b1;
		else if (start || stop)
			sda_oe_n_o <= 1'b1;
		else if (scl_fall)
			sda_oe_n_o <= !(st_r == ST_AACK || st_r == ST_RACK ||
				st_r == ST_WACK || (st_r == ST_RDAT && !tx_r[7]));
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_stb_o <= 1'b0;
			wr_data_o <= 8'h00;
			txn_end_o <= 1'b0;
		end else begin
			wr_stb_o <= scl_rise && !start && !stop && st_r == ST_WDAT &&
				last;
			if (scl_rise && st_r == ST_WDAT && last)
				wr_data_o <= byte_in;
			txn_end_o <= stop;
		end
	end

endmodule // bvs_i2c_slave

// File: hdl/bvs_setpoint_regs.sv
`timescale 1ns/1ns
// How it works
// - second converter register at 0x0F, reset value 0x08.
// - third converter register at 0x10, reset value 0x08.
// - both converter registers accept writes only after unlock.
// - bit 7 picks external adjust (1) or register code (0).
// - bit 6 reads zero and ignores writes.
// - codes 0 to 0x17 give 0.9 V plus 25 mV per step.
// - codes 0x18 to 0x1F give 1.5 V to 1.85 V, 50 mV steps.
// - codes 0x20 to 0x2F give 1.9 V to 2.65 V, 50 mV steps.
// - codes 0x30-0x34 give 2.7-2.9 V; 0x35-0x37 give 3.0/3.1/3.2 V.
// - codes 0x38 and above all give 3.3 V.
// - second converter code bit 0 is fixed.
// - third converter code bits 5 and 0 are fixed.
// - third converter code resets to 0x08.
// - key 0x7D unlocks one following write; other keys lock.
// - key clears after the transaction following the unlock one.
// - new code applies on go bit, or on any accepted setpoint register write when bypassed.
module bvs_setpoint_regs import bvs_pkg::*; (
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_N_O,
	output logic [5:0] BUCK2_CODE_O,
	output logic [5:0] BUCK3_CODE_O,
	output logic BUCK2_EXT_O,
	output logic BUCK3_EXT_O,
	output logic [11:0] BUCK2_MV_O,
	output logic [11:0] BUCK3_MV_O,
	output logic TRANSITION_O
);

	logic wr_stb, txn_end, unlocked, accept, go_now, apply_r;
	logic [7:0] wr_data, ptr, rd_data;
	logic [7:0] unlock_key_r;
	logic key_seen_r;
	logic [7:0] buck_two_setpoint_control_r;
	logic [7:0] buck_three_setpoint_control_r;
	logic [7:0] ctl_r;
	logic transition_trigger_bypass;

	function automatic logic is_prot(input logic [7:0] a);
		return a == B2_OFS || a == B3_OFS || a == CTL_OFS;
	endfunction

	function automatic logic [11:0] code_to_mv(input logic [5:0] c);
		logic [11:0] w;
		w = {6'h00, c};
		if (c < CODE_SEG2)
			return MV_0900 + w * STEP_FINE;
		if (c < CODE_SEG3)
			return MV_1500 + (w - {6'h00, CODE_SEG2}) * STEP_COARSE;
		if (c < CODE_SEG4)
			return MV_1900 + (w - {6'h00, CODE_SEG3}) * STEP_COARSE;
		if (c <= CODE_SEG4_END)
			return MV_2700 + (w - {6'h00, CODE_SEG4}) * STEP_COARSE;
		if (c == CODE_3V0)
			return MV_3000;
		if (c == CODE_3V1)
			return MV_3100;
		if (c == CODE_3V2)
			return MV_3200;
		return MV_3300;
	endfunction

	bvs_i2c_slave u_slave (
		.clk_i(CLK_I),
		.arst_n_i(ARST_N_I),
		.scl_i(SCL_I),
		.sda_i(SDA_I),
		.rd_data_i(rd_data),
		.sda_oe_n_o(SDA_OE_N_O),
		.wr_stb_o(wr_stb),
		.wr_data_o(wr_data),
		.ptr_o(ptr),
		.txn_end_o(txn_end)
	);

	// open drain: the pin is only ever pulled low
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I)
			SDA_O <= 1'b0;
		else
			SDA_O <= 1'b0;
	end

	assign transition_trigger_bypass = ctl_r[BYP_BIT];
	// only the exact key opens the lock
	assign unlocked = unlock_key_r == UNLOCK_KEY;
	// protected writes need the lock open
	assign accept = wr_stb && is_prot(ptr) && unlocked;
	assign go_now = accept && ptr == CTL_OFS && wr_data[GO_BIT];

	// key survives only its own transaction and the next one
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			unlock_key_r <= KEY_RST;
			key_seen_r <= 1'b0;
		end else if (wr_stb && ptr == KEY_OFS) begin
			unlock_key_r <= wr_data;
			key_seen_r <= 1'b1;
		end else begin
			if (accept || (txn_end && !key_seen_r))
				unlock_key_r <= KEY_RST;
			if (txn_end)
				key_seen_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I)
			buck_two_setpoint_control_r <= B2_RST;
		else if (accept && ptr == B2_OFS)
			// fixed bits kept by the mask
			buck_two_setpoint_control_r <= (wr_data & B2_WMASK) |
				(B2_RST & ~B2_WMASK);
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I)
			buck_three_setpoint_control_r <= B3_RST;
		else if (accept && ptr == B3_OFS)
			// fixed bits kept by the mask
			buck_three_setpoint_control_r <= (wr_data & B3_WMASK) |
				(B3_RST & ~B3_WMASK);
	end

	// go bit self-clears once the new codes are applied
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I)
			ctl_r <= CTL_RST;
		else if (accept && ptr == CTL_OFS)
			ctl_r <= wr_data;
		else if (apply_r)
			ctl_r[GO_BIT] <= 1'b0;
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I)
			apply_r <= 1'b0;
		else
			apply_r <= go_now || (transition_trigger_bypass && accept &&
				(ptr == B2_OFS || ptr == B3_OFS));
	end

	// applied one cycle after the store, so the new value is used
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			BUCK2_CODE_O <= B2_RST[5:0];
			BUCK3_CODE_O <= B3_RST[5:0];
			BUCK2_MV_O <= MV_RST;
			BUCK3_MV_O <= MV_RST;
		end else if (apply_r) begin
			BUCK2_CODE_O <= buck_two_setpoint_control_r[5:0];
			BUCK3_CODE_O <= buck_three_setpoint_control_r[5:0];
			BUCK2_MV_O <= code_to_mv(buck_two_setpoint_control_r[5:0]);
			BUCK3_MV_O <= code_to_mv(buck_three_setpoint_control_r[5:0]);
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I)
			TRANSITION_O <= 1'b0;
		else
			TRANSITION_O <= apply_r;
	end

	// source select follows the stored bit
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			BUCK2_EXT_O <= B2_RST[XADJ_BIT];
			BUCK3_EXT_O <= B3_RST[XADJ_BIT];
		end else begin
			BUCK2_EXT_O <= buck_two_setpoint_control_r[XADJ_BIT];
			BUCK3_EXT_O <= buck_three_setpoint_control_r[XADJ_BIT];
		end
	end

	// unmapped reads return zero
	always_comb begin
		case (ptr)
			KEY_OFS: rd_data = unlock_key_r;
			B2_OFS: rd_data = buck_two_setpoint_control_r;
			B3_OFS: rd_data = buck_three_setpoint_control_r;
			CTL_OFS: rd_data = ctl_r;
			default: rd_data = 8'h00;
		endcase
	end

	property p_b2_reset;
		@(posedge CLK_I) disable iff (!ARST_N_I)
		$rose(ARST_N_I) |-> buck_two_setpoint_control_r == B2_RST;
	endproperty
	a_b2_reset: assert property (p_b2_reset)
		else $error("second register reset value wrong");

	property p_b3_reset;
		@(posedge CLK_I) disable iff (!ARST_N_I)
		$rose(ARST_N_I) |-> buck_three_setpoint_control_r == B3_RST &&
			BUCK3_CODE_O == 6'h08;
	endproperty
	a_b3_reset: assert property (p_b3_reset)
		else $error("third register reset value wrong");

	property p_locked_drop;
		@(posedge CLK_I) disable iff (!ARST_N_I)
		wr_stb && !unlocked |=> $stable(buck_two_setpoint_control_r) &&
			$stable(buck_three_setpoint_control_r) && $stable(ctl_r);
	endproperty
	a_locked_drop: assert property (p_locked_drop)
		else $error("locked write changed a register");

	property p_unlocked_write;
		@(posedge CLK_I) disable iff (!ARST_N_I)
		wr_stb && unlocked && ptr == B3_OFS |=>
			buck_three_setpoint_control_r[XADJ_BIT] ==
			$past(wr_data[XADJ_BIT]) && unlock_key_r == KEY_RST;
	endproperty
	a_unlocked_write: assert property (p_unlocked_write)
		else $error("unlocked write not taken or lock not rearmed");

	property p_one_write;
		@(posedge CLK_I) disable iff (!ARST_N_I)
		accept |=> !unlocked;
	endproperty
	a_one_write: assert property (p_one_write)
		else $error("lock stayed open after a write");

	property p_key_expire;
		@(posedge CLK_I) disable iff (!ARST_N_I)
		txn_end && !key_seen_r && !(wr_stb && ptr == KEY_OFS) |=>
			unlock_key_r == KEY_RST;
	endproperty
	a_key_expire: assert property (p_key_expire)
		else $error("key not cleared after transaction");

	property p_rsvd_zero;
		@(posedge CLK_I) disable iff (!ARST_N_I)
		buck_two_setpoint_control_r[RSVD_BIT] == 1'b0 &&
			buck_three_setpoint_control_r[RSVD_BIT] == 1'b0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved bit set");

	property p_fixed_bits;
		@(posedge CLK_I) disable iff (!ARST_N_I)
		buck_two_setpoint_control_r[0] == B2_RST[0] &&
			buck_three_setpoint_control_r[5] == B3_RST[5] &&
			buck_three_setpoint_control_r[0] == B3_RST[0];
	endproperty
	a_fixed_bits: assert property (p_fixed_bits)
		else $error("fixed code bit changed");

	property p_fine_map;
		@(posedge CLK_I) disable iff (!ARST_N_I)
		BUCK2_CODE_O < 6'h18 |-> BUCK2_MV_O ==
			12'h384 + 12'h019 * {6'h00, BUCK2_CODE_O};
	endproperty
	a_fine_map: assert property (p_fine_map)
		else $error("fine segment voltage wrong");

	property p_sat_map;
		@(posedge CLK_I) disable iff (!ARST_N_I)
		BUCK2_CODE_O >= 6'h38 |-> BUCK2_MV_O == 12'hCE4;
	endproperty
	a_sat_map: assert property (p_sat_map)
		else $error("top codes do not saturate");

	property p_ext_follow;
		@(posedge CLK_I) disable iff (!ARST_N_I)
		##1 BUCK2_EXT_O == $past(buck_two_setpoint_control_r[XADJ_BIT]);
	endproperty
	a_ext_follow: assert property (p_ext_follow)
		else $error("source select does not follow register");

	property p_bypass_apply;
		@(posedge CLK_I) disable iff (!ARST_N_I)
		accept && transition_trigger_bypass && ptr == B2_OFS |=>
			##1 TRANSITION_O &&
			BUCK2_CODE_O == buck_two_setpoint_control_r[5:0];
	endproperty
	a_bypass_apply: assert property (p_bypass_apply)
		else $error("bypassed write did not start transition");

	property p_hold_no_go;
		@(posedge CLK_I) disable iff (!ARST_N_I)
		!apply_r |=> $stable(BUCK2_CODE_O) && $stable(BUCK3_CODE_O);
	endproperty
	a_hold_no_go: assert property (p_hold_no_go)
		else $error("code changed without trigger");

endmodule // bvs_setpoint_regs

// File: tb/bvs_host_model.sv
`timescale 1ns/1ns
module bvs_host_model import bvs_pkg::*; (
	input wire logic clk_i,
	input wire logic sda_oe_n_i,
	output logic scl_o,
	output logic sda_o
);
	logic drv_r;
	// open-drain line, pull-up wins when nobody pulls
	assign sda_o = drv_r & sda_oe_n_i;
	initial begin
		scl_o = 1'b1;
		drv_r = 1'b1;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// data moves only while the bus clock is low
	task automatic put(input logic b, output logic s);
		scl_o = 1'b0;
		hold(2);
		drv_r = b;
		hold(2);
		scl_o = 1'b1;
		hold(4);
		s = sda_o;
	endtask
	task automatic start();
		scl_o = 1'b0;
		hold(2);
		drv_r = 1'b1;
		hold(2);
		scl_o = 1'b1;
		hold(4);
		drv_r = 1'b0;
		hold(4);
	endtask
	task automatic stop();
		scl_o = 1'b0;
		hold(2);
		drv_r = 1'b0;
		hold(2);
		scl_o = 1'b1;
		hold(4);
		drv_r = 1'b1;
		hold(4);
	endtask
	task automatic byte_io(input logic [7:0] tx, input logic last,
		output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			put(tx[i], rx[i]);
		end
		put(last, ack);
	endtask
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d,
		output logic ok);
		logic [7:0] rx;
		logic a0, a1, a2;
		start();
		byte_io({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
		byte_io(ofs, 1'b1, rx, a1);
		byte_io(d, 1'b1, rx, a2);
		stop();
		ok = !(a0 | a1 | a2);
	endtask
	task automatic rd(input logic [7:0] ofs, output logic [7:0] v);
		logic [7:0] rx;
		logic a;
		start();
		byte_io({DEV_ADDR, 1'b0}, 1'b1, rx, a);
		byte_io(ofs, 1'b1, rx, a);
		start();
		byte_io({DEV_ADDR, 1'b1}, 1'b1, rx, a);
		// single byte read, nack ends it
		byte_io(8'hFF, 1'b1, v, a);
		stop();
	endtask
	task automatic unlock_wr(input logic [7:0] ofs, input logic [7:0] d,
		output logic ok);
		logic k;
		wr(KEY_OFS, UNLOCK_KEY, k);
		wr(ofs, d, ok);
		ok = ok & k;
	endtask
endmodule // bvs_host_model

// File: tb/test_buck_voltage_setpoint_regs.sv
`timescale 1ns/1ns
module test_buck_voltage_setpoint_regs import bvs_pkg::*;;
	logic clk, arst_n, scl, sda, sda_o, oe_n, b2x, b3x, trn;
	logic [5:0] c2, c3;
	logic [11:0] mv2, mv3;
	int n_errors = 0;
	int num_checks = 0;
	int n_trn = 0;
	initial clk = 1'b0;
	always #5 clk = ~clk;
	always @(negedge clk) begin
		if (trn === 1'b1) begin
			n_trn++;
		end
	end
	bvs_setpoint_regs dut_u (.CLK_I(clk), .ARST_N_I(arst_n), .SCL_I(scl),
		.SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N_O(oe_n), .BUCK2_CODE_O(c2),
		.BUCK3_CODE_O(c3), .BUCK2_EXT_O(b2x), .BUCK3_EXT_O(b3x),
		.BUCK2_MV_O(mv2), .BUCK3_MV_O(mv3), .TRANSITION_O(trn));
	bvs_host_model host_u (.clk_i(clk), .sda_oe_n_i(oe_n), .scl_o(scl),
		.sda_o(sda));
	function automatic logic [11:0] mv_of(input logic [5:0] c);
		if (c < CODE_SEG2) return MV_0900 + STEP_FINE * c;
		if (c < CODE_SEG3) return MV_1500 + STEP_COARSE * (c - CODE_SEG2);
		if (c < CODE_SEG4) return MV_1900 + STEP_COARSE * (c - CODE_SEG3);
		if (c <= CODE_SEG4_END) return MV_2700 + STEP_COARSE * (c - CODE_SEG4);
		if (c == CODE_3V0) return MV_3000;
		if (c == CODE_3V1) return MV_3100;
		if (c == CODE_3V2) return MV_3200;
		return MV_3300;
	endfunction
	// fixed code bits stay at their reset value of zero
	function automatic logic [7:0] exp_reg(input logic s3, input logic [7:0] d);
		return s3 ? {d[7], 2'h0, d[4:1], 1'b0} : {d[7], 1'b0, d[5:1], 1'b0};
	endfunction
	task automatic chk(input logic [11:0] got, input logic [11:0] exp,
		input string what);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic set_chk(input logic s3, input logic [7:0] d);
		logic [7:0] e, v, ofs;
		logic ok;
		e = exp_reg(s3, d);
		ofs = s3 ? B3_OFS : B2_OFS;
		host_u.unlock_wr(ofs, d, ok);
		chk(ok, 1'b1, "ack");
		chk(sda_o, 1'b0, "sdaval");
		host_u.rd(ofs, v);
		chk(v, e, "readback");
		chk(s3 ? {b3x, c3} : {b2x, c2}, {e[7], e[5:0]}, "applied");
		chk(s3 ? mv3 : mv2, mv_of(e[5:0]), "mv");
		host_u.rd(KEY_OFS, v);
		chk(v, 8'h00, "key");
	endtask
	initial begin
		#900000;
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		complete_run();
	end
	initial begin
		logic [7:0] v, d;
		logic ok;
		int t0;
		logic [7:0] keys [4];
		keys = '{8'h00, 8'h7C, 8'h7E, 8'hFF};
		arst_n = 1'b0;
		void'($urandom(32'hCB33F11B));
		repeat (4) @(negedge clk);
		arst_n = 1'b1;
		@(negedge clk);
		chk({b2x, c2}, 12'h008, "rst2");
		chk({b3x, c3}, 12'h008, "rst3");
		chk(mv3, mv_of(6'h08), "rstmv");
		host_u.rd(B2_OFS, v);
		chk(v, 8'h08, "rd2");
		host_u.rd(B3_OFS, v);
		chk(v, 8'h08, "rd3");
		host_u.wr(B2_OFS, 8'h3E, ok);
		host_u.rd(B2_OFS, v);
		chk(v, 8'h08, "locked");
		foreach (keys[i]) begin
			host_u.wr(KEY_OFS, keys[i], ok);
			host_u.wr(B3_OFS, 8'h9E, ok);
			host_u.rd(B3_OFS, v);
			chk(v, 8'h08, "badkey");
		end
		// unused key expires with the next transaction
		host_u.wr(KEY_OFS, UNLOCK_KEY, ok);
		host_u.rd(KEY_OFS, v);
		chk(v, UNLOCK_KEY, "keyrd");
		host_u.wr(B2_OFS, 8'h3E, ok);
		host_u.rd(B2_OFS, v);
		chk(v, 8'h08, "expired");
		// bypass on so every unlocked setpoint write applies at once
		host_u.unlock_wr(CTL_OFS, 8'h40, ok);
		for (int i = 0; i < 32; i++) begin
			d = 8'($urandom);
			d[5:1] = i[4:0];
			set_chk(1'b0, d);
			host_u.wr(B2_OFS, ~d, ok);
			host_u.rd(B2_OFS, v);
			chk(v, exp_reg(1'b0, d), "oneshot");
		end
		for (int i = 0; i < 16; i++) begin
			d = 8'($urandom);
			d[4:1] = i[3:0];
			set_chk(1'b1, d);
		end
		set_chk(1'b1, 8'hFF);
		chk(mv3, 12'h708, "mv1800");
		set_chk(1'b0, 8'hFF);
		chk(mv2, 12'hCE4, "mv3300");
		set_chk(1'b0, 8'h00);
		host_u.unlock_wr(CTL_OFS, 8'h00, ok);
		host_u.unlock_wr(B2_OFS, 8'h20, ok);
		chk(c2, 6'h00, "held");
		t0 = n_trn;
		host_u.unlock_wr(CTL_OFS, 8'h80, ok);
		chk(c2, 6'h20, "go");
		chk(mv2, mv_of(6'h20), "gomv");
		chk(12'(n_trn - t0), 12'h001, "pulse");
		host_u.rd(CTL_OFS, v);
		chk(v, 8'h00, "goclr");
		complete_run();
	end
endmodule // test_buck_voltage_setpoint_regs
